/* File: hw/lcc_pkg.sv */
package lcc_pkg;
    localparam int NCELL      = 10;
    localparam int NLANE      = 26;
    localparam int NLOCAL     = 36;
    localparam int NCOL       = 4;
    localparam int NCTRL      = 10;
    localparam int SELW       = 6;
    localparam int AW         = 8;
    localparam int DW         = 32;

    // Cluster-wide control slots.
    localparam int C_CLK0     = 0;
    localparam int C_CLK1     = 1;
    localparam int C_ENA0     = 2;
    localparam int C_ENA1     = 3;
    localparam int C_ACLR0    = 4;
    localparam int C_ACLR1    = 5;
    localparam int C_SCLR     = 6;
    localparam int C_ALOAD    = 7;
    localparam int C_SLOAD    = 8;
    localparam int C_ADDNSUB  = 9;

    // Level of each control while its slot is unused: enables stay high.
    localparam logic [NCTRL-1:0] CTRL_IDLE = 10'h00C;

    // Byte offsets of the register map.
    localparam logic [AW-1:0] OFS_CSEL0 = 8'h00;
    localparam logic [AW-1:0] OFS_CSEL1 = 8'h04;
    localparam logic [AW-1:0] OFS_CUSE  = 8'h08;
    localparam logic [AW-1:0] OFS_STAT  = 8'h0C;
    localparam logic [AW-1:0] OFS_LANE  = 8'h10;
    localparam logic [AW-1:0] OFS_CELL  = 8'h20;
    localparam logic [AW-1:0] OFS_END   = 8'h70;

    // Field positions.
    localparam int CUSE_FALL  = 10;
    localparam int A_SEL0     = 16;
    localparam int A_SEL1     = 22;
    localparam int B_SEL2     = 0;
    localparam int B_SEL3     = 6;
    localparam int B_LCHAIN   = 12;
    localparam int B_RCHAIN   = 13;
    localparam int B_CLKSEL   = 14;
    localparam int B_ACLRSEL  = 15;
    localparam int B_ACLREN   = 16;
    localparam int B_ARITH    = 17;
    localparam int B_INV      = 18;
    localparam int B_OUTREG   = 19;

    localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic carry;
        logic lut;
        logic q;
    } lcc_chain_t;
endpackage : lcc_pkg

/* File: hw/lcc_cluster.sv */
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
// How it works
// - Exactly ten cells share controls and interconnect.
// - Twenty-six external lanes plus ten feedback lines.
// - LUT output chains into the next cell.
// - Register output chains into next cell's register.
// - Ten shared controls, never more than ten.
// - Each cluster clock tied to its enable.
// - Each cluster clock uses one edge, rising or falling.
// - Low enable stops its clock; registers hold.
// - Preset by inversion or aload with data high.
// - Add/subtract select makes cells adders or subtractors.
// - Four column clocks reach the cluster.
// - Controls come from column clocks or local lines.
// - Local lines fed by fabric, feedback, neighbours.
// - Each cell output reaches thirty cells.
// - Sync clear and load hit all registers together.
// - Subtract inverts B, forces first carry-in high.
module lcc_cluster (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic [lcc_pkg::NCOL-1:0]   col_clk,
    input  wire logic [lcc_pkg::NLANE-1:0]  fabric_in,
    input  wire logic [lcc_pkg::NCELL-1:0]  nbr_left_in,
    input  wire logic [lcc_pkg::NCELL-1:0]  nbr_right_in,
    input  wire lcc_pkg::lcc_chain_t        chain_in,
    input  wire logic [lcc_pkg::AW-1:0]     avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [lcc_pkg::DW-1:0]     avs_writedata,
    output logic      [lcc_pkg::DW-1:0]     avs_readdata,
    output logic                            avs_waitrequest,
    output logic      [lcc_pkg::NCELL-1:0]  cell_out,
    output lcc_pkg::lcc_chain_t             chain_out
);
    localparam int NC = lcc_pkg::NCELL;

    logic [lcc_pkg::NCOL-1:0]       cs1_r;
    logic [lcc_pkg::NCOL-1:0]       cs2_r;
    logic [lcc_pkg::NCOL-1:0]       cs3_r;
    logic [lcc_pkg::NCOL-1:0]       col_r;
    logic [59:0]                    csel_r;
    logic [lcc_pkg::NCTRL-1:0]      cuse_r;
    logic [1:0]                     fall_r;
    logic [19:0]                    lane_r;
    logic [lcc_pkg::DW-1:0]         cfg_a_r [NC];
    logic [lcc_pkg::DW-1:0]         cfg_b_r [NC];
    logic [1:0]                     clkp_r;

    logic [lcc_pkg::NLANE-1:0]      lane_w;
    logic [lcc_pkg::NLOCAL-1:0]     local_w;
    logic [63:0]                    pool_w;
    logic [lcc_pkg::NCTRL-1:0]      ctrl_w;
    logic [1:0]                     edge_w;
    logic [1:0]                     tick_w;
    logic [NC-1:0]                  lut_w;
    logic [NC-1:0]                  qo_w;
    logic [NC-1:0]                  out_nxt;
    logic [NC:0]                    cy_w;
    logic [NC:0]                    lc_w;
    logic [NC:0]                    qc_w;

    // Column clocks arrive from pins; a level counts once two late stages agree.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs1_r <= 4'h0;
            cs2_r <= 4'h0;
            cs3_r <= 4'h0;
            col_r <= 4'h0;
        end else begin
            cs1_r <= col_clk;
            cs2_r <= cs1_r;
            cs3_r <= cs2_r;
            col_r <= (cs2_r & cs3_r) | (col_r & (cs2_r | cs3_r));
        end
    end

    // Lanes 0..9 may take the left neighbour, lanes 16..25 the right one.
    assign lane_w = {(fabric_in[25:16] & ~lane_r[19:10]) | (nbr_right_in & lane_r[19:10]),
                     fabric_in[15:10],
                     (fabric_in[9:0] & ~lane_r[9:0]) | (nbr_left_in & lane_r[9:0])};
    // Feedback uses the registered cell outputs, so no cell can close a combinational loop.
    assign local_w = {cell_out, lane_w};
    assign pool_w  = {24'h00_0000, local_w, col_r};

    for (genvar k = 0; k < lcc_pkg::NCTRL; k++) begin : g_ctrl
        assign ctrl_w[k] = cuse_r[k] ? pool_w[csel_r[k*lcc_pkg::SELW +: lcc_pkg::SELW]]
                                     : lcc_pkg::CTRL_IDLE[k];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkp_r <= 2'h0;
        end else begin
            clkp_r <= ctrl_w[1:0];
        end
    end

    for (genvar k = 0; k < 2; k++) begin : g_clk
        assign edge_w[k] = fall_r[k] ? (clkp_r[k] & ~ctrl_w[k]) : (~clkp_r[k] & ctrl_w[k]);
        assign tick_w[k] = edge_w[k] & ctrl_w[lcc_pkg::C_ENA0 + k];
    end

    assign lc_w[0] = chain_in.lut;
    assign qc_w[0] = chain_in.q;
    assign cy_w[0] = ctrl_w[lcc_pkg::C_ADDNSUB] | chain_in.carry;

    for (genvar i = 0; i < NC; i++) begin : g_cell
        logic [31:0] a;
        logic [31:0] b;
        logic        d0;
        logic        d1;
        logic        d2;
        logic        d3;
        logic        bop;
        logic        lut;
        logic        inv;
        logic        dsel;
        logic        aclr;
        logic        tick;
        logic        qs_r;

        assign a    = cfg_a_r[i];
        assign b    = cfg_b_r[i];
        assign d0   = b[lcc_pkg::B_LCHAIN] ? lc_w[i] : pool_w[a[lcc_pkg::A_SEL0 +: lcc_pkg::SELW]];
        assign d1   = pool_w[a[lcc_pkg::A_SEL1 +: lcc_pkg::SELW]];
        assign d2   = pool_w[b[lcc_pkg::B_SEL2 +: lcc_pkg::SELW]];
        assign d3   = pool_w[b[lcc_pkg::B_SEL3 +: lcc_pkg::SELW]];
        assign bop  = d1 ^ ctrl_w[lcc_pkg::C_ADDNSUB];
        assign lut  = b[lcc_pkg::B_ARITH] ? (d0 ^ bop ^ cy_w[i]) : a[{d3, d2, d1, d0}];
        assign cy_w[i+1] = b[lcc_pkg::B_ARITH] ? ((d0 & bop) | (cy_w[i] & (d0 ^ bop))) : 1'b0;
        assign inv  = b[lcc_pkg::B_INV];
        assign dsel = b[lcc_pkg::B_RCHAIN] ? qc_w[i] : lut;
        assign aclr = b[lcc_pkg::B_ACLREN] & ctrl_w[lcc_pkg::C_ACLR0 + int'(b[lcc_pkg::B_ACLRSEL])];
        assign tick = tick_w[b[lcc_pkg::B_CLKSEL]];

        // With inversion on, the stored bit is the complement, so a clear reads back as a preset.
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                qs_r <= 1'b0;
            end else if (aclr) begin
                qs_r <= 1'b0;
            end else if (ctrl_w[lcc_pkg::C_ALOAD]) begin
                qs_r <= d3 ^ inv;
            end else if (tick) begin
                if (ctrl_w[lcc_pkg::C_SCLR]) begin
                    qs_r <= 1'b0;
                end else if (ctrl_w[lcc_pkg::C_SLOAD]) begin
                    qs_r <= d2 ^ inv;
                end else begin
                    qs_r <= dsel ^ inv;
                end
            end
        end

        assign qo_w[i]    = qs_r ^ inv;
        assign lut_w[i]   = lut;
        assign lc_w[i+1]  = lut;
        assign qc_w[i+1]  = qo_w[i];
        assign out_nxt[i] = b[lcc_pkg::B_OUTREG] ? qo_w[i] : lut;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cell_out  <= 10'h000;
            chain_out <= 3'h0;
        end else begin
            cell_out        <= out_nxt;
            chain_out.carry <= cy_w[NC];
            chain_out.lut   <= lut_w[NC-1];
            chain_out.q     <= qo_w[NC-1];
        end
    end

    // Register slave: every access waits exactly one cycle.
    logic                   req_w;
    logic                   wr_w;
    logic [lcc_pkg::AW-1:0] cofs_w;
    logic [3:0]             cidx_w;
    logic                   cell_hit_w;
    logic [lcc_pkg::DW-1:0] cell_rd_w;
    logic [lcc_pkg::DW-1:0] rdata_w;

    assign req_w      = avs_read | avs_write;
    assign wr_w       = avs_write & ~avs_waitrequest;
    assign cofs_w     = avs_address - lcc_pkg::OFS_CELL;
    assign cidx_w     = cofs_w[6:3];
    assign cell_hit_w = (avs_address >= lcc_pkg::OFS_CELL) && (avs_address < lcc_pkg::OFS_END)
                        && (avs_address[1:0] == 2'h0);
    assign cell_rd_w  = cofs_w[2] ? cfg_b_r[cidx_w] : cfg_a_r[cidx_w];
    assign rdata_w    = (avs_address == lcc_pkg::OFS_CSEL0) ? {2'h0, csel_r[29:0]} :
                        (avs_address == lcc_pkg::OFS_CSEL1) ? {2'h0, csel_r[59:30]} :
                        (avs_address == lcc_pkg::OFS_CUSE)  ? {20'h0_0000, fall_r, cuse_r} :
                        (avs_address == lcc_pkg::OFS_STAT)  ? {2'h0, ctrl_w, lut_w, qo_w} :
                        (avs_address == lcc_pkg::OFS_LANE)  ? {12'h000, lane_r} :
                        cell_hit_w                          ? cell_rd_w :
                                                              lcc_pkg::RST_WORD;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= lcc_pkg::RST_WORD;
        end else begin
            avs_waitrequest <= ~(req_w & avs_waitrequest);
            if (req_w & avs_waitrequest) begin
                avs_readdata <= rdata_w;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csel_r <= 60'h000_0000_0000_0000;
            cuse_r <= 10'h000;
            fall_r <= 2'h0;
            lane_r <= 20'h0_0000;
            for (int i = 0; i < NC; i++) begin
                cfg_a_r[i] <= lcc_pkg::RST_WORD;
                cfg_b_r[i] <= lcc_pkg::RST_WORD;
            end
        end else if (wr_w) begin
            if (avs_address == lcc_pkg::OFS_CSEL0) begin
                csel_r[29:0] <= avs_writedata[29:0];
            end
            if (avs_address == lcc_pkg::OFS_CSEL1) begin
                csel_r[59:30] <= avs_writedata[29:0];
            end
            if (avs_address == lcc_pkg::OFS_CUSE) begin
                cuse_r <= avs_writedata[9:0];
                fall_r <= avs_writedata[lcc_pkg::CUSE_FALL +: 2];
            end
            if (avs_address == lcc_pkg::OFS_LANE) begin
                lane_r <= avs_writedata[19:0];
            end
            if (cell_hit_w && !cofs_w[2]) begin
                cfg_a_r[cidx_w] <= avs_writedata;
            end
            if (cell_hit_w && cofs_w[2]) begin
                cfg_b_r[cidx_w] <= avs_writedata;
            end
        end
    end
endmodule : lcc_cluster

/* File: tb/lcc_cluster_checker.sv */
`timescale 1ns/1ps
module lcc_cluster_checker (
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic [lcc_pkg::AW-1:0]    avs_address,
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [lcc_pkg::DW-1:0]    avs_readdata,
    input wire logic                      avs_waitrequest,
    input wire logic [lcc_pkg::NCELL-1:0] cell_out,
    input wire lcc_pkg::lcc_chain_t       chain_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Holes between the lane word and the cell words decode to nothing as well.
    wire unmapped = (avs_address >= lcc_pkg::OFS_END)
                  || (avs_address > lcc_pkg::OFS_LANE && avs_address < lcc_pkg::OFS_CELL);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_reset_vals: assert property ($fell(sys_rst) |-> avs_waitrequest && avs_readdata == '0)
        else $error("bus outputs not idle after reset");
    a_cells_quiet: assert property ($fell(sys_rst) |-> (cell_out == '0 && chain_out == '0) [*2])
        else $error("cell outputs not cleared after reset");
    a_answer_next: assert property (s_req |=> s_ans)
        else $error("access not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write) && $past(avs_waitrequest))
        else $error("waitrequest low without a request");
    a_no_spont: assert property ((!(avs_read || avs_write)) [*2] |-> avs_waitrequest)
        else $error("waitrequest low while bus idle");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && unmapped |=> avs_readdata == '0)
        else $error("unmapped read returned nonzero");
    a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("readdata changed outside an answer");
endmodule : lcc_cluster_checker
bind lcc_cluster lcc_cluster_checker lcc_cluster_checker_i (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cell_out(cell_out), .chain_out(chain_out));

/* File: tb/lcc_fabric_model.sv */
`timescale 1ns/1ps
module lcc_fabric_model (
    input  wire logic                      clk,
    input  wire logic [lcc_pkg::NLANE-1:0] lanes,
    output logic      [lcc_pkg::NCOL-1:0]  col_clk,
    output logic      [lcc_pkg::NLANE-1:0] fabric_in,
    output logic      [lcc_pkg::NCELL-1:0] nbr_left_in,
    output logic      [lcc_pkg::NCELL-1:0] nbr_right_in,
    output lcc_pkg::lcc_chain_t            chain_in
);
    logic [3:0] div_r;
    initial begin
        div_r = 4'h0;
        col_clk = '0;
        fabric_in = '0;
        nbr_left_in = '0;
        nbr_right_in = '0;
        chain_in = '0;
    end
    // Neighbour lines keep changing so an unselected neighbour can never pass for a steady level.
    always @(posedge clk) begin
        div_r <= div_r + 4'h1;
        col_clk <= {3'h0, div_r[3]};
        fabric_in <= lanes;
        nbr_left_in <= {5{div_r[1:0]}};
        nbr_right_in <= ~{5{div_r[1:0]}};
        chain_in <= '0;
    end
endmodule : lcc_fabric_model

/* File: tb/tb_lcc_cluster.sv */
`timescale 1ns/1ps
module tb_lcc_cluster;
    logic                       clk = 1'b0;
    logic                       sys_rst = 1'b1;
    logic [lcc_pkg::NLANE-1:0]  lanes = '0;
    logic [lcc_pkg::AW-1:0]     avs_address = '0;
    logic                       avs_read = 1'b0;
    logic                       avs_write = 1'b0;
    logic [lcc_pkg::DW-1:0]     avs_writedata = '0;
    logic [lcc_pkg::DW-1:0]     avs_readdata, rd;
    logic                       avs_waitrequest;
    logic [lcc_pkg::NCOL-1:0]   col_clk;
    logic [lcc_pkg::NLANE-1:0]  fabric_in;
    logic [lcc_pkg::NCELL-1:0]  nbr_left_in, nbr_right_in, cell_out;
    lcc_pkg::lcc_chain_t        chain_in, chain_out;
    int                         miscompares = 0;
    int                         cmp_count = 0;
    always #25 clk = ~clk;
    lcc_fabric_model lcc_fabric_model_i (.clk(clk), .lanes(lanes), .col_clk(col_clk), .fabric_in(fabric_in),
        .nbr_left_in(nbr_left_in), .nbr_right_in(nbr_right_in), .chain_in(chain_in));
    lcc_cluster lcc_cluster_i (.clk(clk), .sys_rst(sys_rst), .col_clk(col_clk), .fabric_in(fabric_in),
        .nbr_left_in(nbr_left_in), .nbr_right_in(nbr_right_in), .chain_in(chain_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cell_out(cell_out), .chain_out(chain_out));
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            miscompares++;
            report_and_stop;
        end
    endtask : bus
    task automatic wait_rise;
        int n;
        logic p;
        p = col_clk[0];
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (col_clk[0] && !p)
                break;
            p = col_clk[0];
        end
        if (n == 40) begin
            miscompares++;
            report_and_stop;
        end
    endtask : wait_rise
    task automatic t_regs;
        bus(0, lcc_pkg::OFS_STAT, '0);
        chk(rd, {2'h0, lcc_pkg::CTRL_IDLE, 20'h0});
        bus(1, lcc_pkg::OFS_CSEL0, 32'hFFFF_FFFF);
        bus(0, lcc_pkg::OFS_CSEL0, '0);
        chk(rd, 32'h3FFF_FFFF);
        bus(1, 8'h74, 32'hFFFF_FFFF);
        bus(0, 8'h74, '0);
        chk(rd, 32'h0000_0000);
        bus(1, lcc_pkg::OFS_CSEL0, '0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_shift;
        bus(1, 8'h20, 32'h0005_AAAA);
        bus(1, 8'h24, 32'h0008_0000);
        bus(1, 8'h2C, 32'h0008_2000);
        bus(1, lcc_pkg::OFS_CSEL0, 32'h0000_6000);
        bus(1, lcc_pkg::OFS_CUSE, 32'h0000_0005);
        lanes[2:1] <= 2'b11;
        repeat (48) @(posedge clk);
        chk(32'(cell_out[1:0]), 32'h3);
        lanes[2:1] <= 2'b00;
        repeat (48) @(posedge clk);
        chk(32'(cell_out[1:0]), 32'h3);
        // Let any column edge already in the synchroniser land while the enable is still low.
        wait_rise;
        repeat (8) @(posedge clk);
        lanes[2] <= 1'b1;
        wait_rise;
        repeat (8) @(posedge clk);
        chk(32'(cell_out[1:0]), 32'h2);
        repeat (16) @(posedge clk);
        chk(32'(cell_out[1:0]), 32'h0);
        $display("t_shift done");
    endtask : t_shift
    task automatic t_fall;
        bus(1, lcc_pkg::OFS_CUSE, 32'h0000_0401);
        lanes[2:1] <= 2'b00;
        wait_rise;
        lanes[1] <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(cell_out[1:0]), 32'h0);
        repeat (8) @(posedge clk);
        chk(32'(cell_out[1:0]), 32'h1);
        $display("t_fall done");
    endtask : t_fall
    task automatic t_arith;
        int k;
        logic [1:0] e;
        sys_rst <= 1'b1;
        lanes <= '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(1, 8'h20, 32'h0207_0000);
        bus(1, 8'h24, 32'h0002_0000);
        bus(1, 8'h28, 32'h075D_0000);
        bus(1, 8'h2C, 32'h0002_0000);
        bus(1, lcc_pkg::OFS_CSEL1, 32'h0900_0000);
        bus(1, lcc_pkg::OFS_CUSE, 32'h0000_0200);
        for (k = 0; k < 8; k++) begin
            lanes[5:3] <= k[2:0];
            repeat (6) @(posedge clk);
            e = k[2] ? 2'(k[0]) - 2'(k[1]) : 2'(k[0]) + 2'(k[1]);
            chk(32'(cell_out[1:0]), 32'(e));
        end
        $display("t_arith done");
    endtask : t_arith
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_shift;
        t_fall;
        t_arith;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop;
    end
endmodule : tb_lcc_cluster
